// file: dv/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input  wire logic       clock,
  input  wire logic [7:0] bus_read_data,
  output logic            bus_select,
  output logic            bus_write,
  output logic            bus_read,
  output logic      [2:0] bus_address,
  output logic      [7:0] bus_write_data
);
  initial begin
    bus_select     = 1'b0;
    bus_write      = 1'b0;
    bus_read       = 1'b0;
    bus_address    = 3'h7;
    bus_write_data = 8'h00;
  end

  // one byte access; strobes drop after the taking edge
  task automatic access(input logic wr, input logic [2:0] addr, input logic [7:0] data,
                        output logic [7:0] rd);
    @(posedge clock);
    bus_select     <= 1'b1;
    bus_write      <= wr;
    bus_read       <= ~wr;
    bus_address    <= addr;
    bus_write_data <= data;
    @(posedge clock);
    bus_select     <= 1'b0;
    bus_write      <= 1'b0;
    bus_read       <= 1'b0;
    // idle lines move, so a design that samples them late sees garbage
    bus_address    <= ~addr;
    bus_write_data <= ~data;
    #1 rd = bus_read_data;
  endtask

  task automatic write_pair(input logic [2:0] hi, input logic [15:0] v);
    logic [7:0] q;
    access(1'b1, hi, v[15:8], q);
    access(1'b1, 3'(hi + 3'h1), v[7:0], q);
  endtask

  task automatic read_pair(input logic [2:0] hi, output logic [15:0] v);
    logic [7:0] q1;
    logic [7:0] q0;
    access(1'b0, hi, 8'h00, q1);
    access(1'b0, 3'(hi + 3'h1), 8'h00, q0);
    v = {q1, q0};
  endtask
endmodule
`default_nettype wire

// file: dv/dual_mode_compare_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_mode_compare_timer_tb;
  import dual_mode_timer_pkg::*;
  localparam int WINDOW = 66;
  localparam logic [7:0] RESET_MAP [8] = '{WRITE_ONLY_READ, STATUS_RESET, COUNT_RESET,
    COUNT_RESET, COMPARE_RESET, COMPARE_RESET, CLOCK_STOP_RESET, UNMAPPED_READ};
  logic        clock;
  logic        reset_n;
  logic        bus_select;
  logic        bus_write;
  logic        bus_read;
  logic [2:0]  bus_address;
  logic [7:0]  bus_write_data;
  logic [7:0]  bus_read_data;
  logic        event_count_pin;
  logic        event_edge_select;
  logic        subclock_tick;
  logic        upper_timer_irq_enable;
  logic        lower_timer_irq_enable;
  logic        upper_toggle_pin;
  logic        lower_toggle_pin;
  logic        upper_irq;
  logic        lower_irq;
  int          errors;
  int          n_compared;
  logic [7:0]  got;
  logic [15:0] v;
  logic [15:0] w;

  dual_mode_compare_timer DUT (.clock(clock), .reset_n(reset_n), .bus_select(bus_select),
    .bus_write(bus_write), .bus_read(bus_read), .bus_address(bus_address),
    .bus_write_data(bus_write_data), .bus_read_data(bus_read_data),
    .event_count_pin(event_count_pin), .event_edge_select(event_edge_select),
    .subclock_tick(subclock_tick), .upper_timer_irq_enable(upper_timer_irq_enable),
    .lower_timer_irq_enable(lower_timer_irq_enable), .upper_toggle_pin(upper_toggle_pin),
    .lower_toggle_pin(lower_toggle_pin), .upper_irq(upper_irq), .lower_irq(lower_irq));

  cpu_bus_model cpu (.clock(clock), .bus_read_data(bus_read_data), .bus_select(bus_select),
    .bus_write(bus_write), .bus_read(bus_read), .bus_address(bus_address),
    .bus_write_data(bus_write_data));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // subclock pulse every second cycle
  initial subclock_tick = 1'b0;
  always @(posedge clock) subclock_tick <= ~subclock_tick;

  function automatic logic [7:0] level_cfg(input logic [1:0] sel);
    return {sel[1], 3'h6, sel[0], 3'h6};
  endfunction

  // ticks in the count window; free-running prescaler phase needs a margin of one
  function automatic logic [7:0] expected_count(input logic [2:0] code);
    int div;
    case (code)
      CKS_DIV32: div = 32;
      CKS_DIV16: div = 16;
      CKS_DIV4:  div = 4;
      default:   div = 8;
    endcase
    return 8'(WINDOW / div);
  endfunction

  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    cpu.access(1'b0, a, 8'h00, q);
  endtask

  task automatic rd_check(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    check({8'h00, q}, {8'h00, e});
  endtask

  task automatic event_pulse;
    @(posedge clock);
    event_count_pin <= 1'b1;
    repeat (3) @(posedge clock);
    event_count_pin <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic wait_irq(input logic upper);
    int k;
    k = 0;
    while (k < 300 && (upper ? upper_irq : lower_irq) !== 1'b1) begin
      @(posedge clock);
      k++;
    end
    if (k == 300) begin
      errors++;
      give_verdict();
    end
  endtask

  initial begin
    int i;
    logic [7:0] exp;
    reset_n = 1'b0;
    event_count_pin = 1'b0;
    event_edge_select = 1'b1;
    upper_timer_irq_enable = 1'b1;
    lower_timer_irq_enable = 1'b0;
    errors = 0;
    n_compared = 0;
    void'($urandom(92));
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd_check(3'(i), RESET_MAP[i]);
    end
    wr(ADDR_CLOCK_STOP, 8'hFB);
    for (i = 0; i < 6; i++) begin
      v = 16'($urandom);
      cpu.write_pair(ADDR_UPPER_COUNT, v);
      repeat (20) @(posedge clock);
      cpu.read_pair(ADDR_UPPER_COUNT, w);
      check(w, v);
      cpu.write_pair(ADDR_UPPER_COMPARE, ~v);
      rd_check(ADDR_LOWER_COMPARE, ~v[7:0]);
      rd_check(ADDR_UPPER_COMPARE, ~v[15:8]);
    end
    wr(ADDR_CLOCK_STOP, 8'hFF);
    v = {8'($urandom), 8'($urandom) & 8'h7F};
    cpu.write_pair(ADDR_UPPER_COUNT, v);
    rd_check(ADDR_UPPER_COUNT, v[15:8]);
    event_pulse();
    rd_check(ADDR_LOWER_COUNT, v[7:0]);
    cpu.read_pair(ADDR_UPPER_COUNT, w);
    check(w, v + 16'h0001);
    event_edge_select <= 1'b0;
    event_pulse();
    cpu.read_pair(ADDR_UPPER_COUNT, w);
    check(w, v + 16'h0002);
    event_edge_select <= 1'b1;
    cpu.write_pair(ADDR_UPPER_COMPARE, 16'h0000);
    cpu.write_pair(ADDR_UPPER_COUNT, 16'hFFFF);
    rd(ADDR_STATUS, got);
    wr(ADDR_STATUS, 8'h20);
    event_pulse();
    wait_irq(1'b1);
    wr(ADDR_STATUS, 8'h20);
    event_pulse();
    rd_check(ADDR_STATUS, 8'hEC);
    check({15'h0, upper_toggle_pin}, 16'h0001);
    wr(ADDR_STATUS, 8'h20);
    rd_check(ADDR_STATUS, 8'h20);
    wr(ADDR_STATUS, 8'hEC);
    rd_check(ADDR_STATUS, 8'h20);
    check({15'h0, upper_irq}, 16'h0000);
    wr(ADDR_CLOCK_STOP, 8'hFB);
    wr(ADDR_CLOCK_LEVEL, 8'h66);
    wr(ADDR_LOWER_COMPARE, 8'h02);
    wr(ADDR_UPPER_COMPARE, 8'h03);
    wr(ADDR_LOWER_COUNT, 8'h00);
    wr(ADDR_UPPER_COUNT, 8'h00);
    rd_check(ADDR_LOWER_COMPARE, 8'h02);
    rd_check(ADDR_UPPER_COUNT, 8'h00);
    lower_timer_irq_enable <= 1'b1;
    wr(ADDR_STATUS, 8'h11);
    wr(ADDR_CLOCK_STOP, 8'hFF);
    repeat (100) @(posedge clock);
    wr(ADDR_CLOCK_STOP, 8'hFB);
    rd(ADDR_STATUS, got);
    check({8'h00, got & 8'hCC}, 16'h0044);
    rd(ADDR_LOWER_COUNT, got);
    check({15'h0, got <= 8'h02}, 16'h0001);
    rd(ADDR_UPPER_COUNT, got);
    check({15'h0, got <= 8'h03}, 16'h0001);
    check({14'h0, upper_irq, lower_irq}, 16'h0003);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_CLOCK_LEVEL, level_cfg(2'(i)));
      check({14'h0, upper_toggle_pin, lower_toggle_pin}, 16'(i));
    end
    rd(ADDR_STATUS, got);
    wr(ADDR_STATUS, 8'h02);
    rd_check(ADDR_STATUS, 8'h02);
    wr(ADDR_UPPER_COMPARE, 8'h10);
    wr(ADDR_LOWER_COMPARE, 8'h10);
    wr(ADDR_UPPER_COUNT, 8'hFE);
    wr(ADDR_LOWER_COUNT, 8'hFE);
    wr(ADDR_CLOCK_STOP, 8'hFF);
    wait_irq(1'b0);
    repeat (20) @(posedge clock);
    wr(ADDR_CLOCK_STOP, 8'hFB);
    rd(ADDR_STATUS, got);
    check({8'h00, got & 8'hCF}, 16'h008A);
    wr(ADDR_STATUS, 8'hCC);
    rd_check(ADDR_STATUS, 8'h88);
    check({14'h0, upper_irq, lower_irq}, 16'h0000);
    for (i = 4; i < 8; i++) begin
      wr(ADDR_LOWER_COUNT, 8'h00);
      wr(ADDR_CLOCK_LEVEL, 8'h60 | 8'(i));
      wr(ADDR_CLOCK_STOP, 8'hFF);
      repeat (64) @(posedge clock);
      wr(ADDR_CLOCK_STOP, 8'hFB);
      rd(ADDR_LOWER_COUNT, got);
      exp = expected_count(3'(i));
      check({15'h0, got >= exp - 8'h01 && got <= exp + 8'h01}, 16'h0001);
    end
    // lower match toggles its own pin in 8-bit mode
    wr(ADDR_LOWER_COMPARE, 8'h00);
    wr(ADDR_LOWER_COUNT, 8'h00);
    wr(ADDR_CLOCK_LEVEL, 8'h40);
    wr(ADDR_CLOCK_STOP, 8'hFF);
    event_pulse();
    check({15'h0, lower_toggle_pin}, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire

// file: hdl/clock_tick_select.sv
`timescale 1ns/1ps
`default_nettype none
module clock_tick_select (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [2:0] select,
  input  wire logic       event_count_pin,
  input  wire logic       event_edge_select,
  input  wire logic       subclock_tick,
  output logic            count_tick
);
  import dual_mode_timer_pkg::*;

  logic [PRESCALE_WIDTH-1:0] div_q;
  logic [PRESCALE_WIDTH-1:0] div_d;
  logic [1:0]                sub_q;
  logic [1:0]                sub_d;
  logic                      pin_q;
  logic                      pin_d;

  function automatic logic div_hit(input logic [4:0] cnt, input logic [4:0] mask);
    div_hit = (cnt & mask) == mask;
  endfunction

  always_comb begin
    div_d = div_q + 5'h01;
    sub_d = subclock_tick ? sub_q + 2'h1 : sub_q;
    pin_d = event_count_pin;
    case (select)
      CKS_DIV32: count_tick = div_hit(div_q, DIV32_MASK);
      CKS_DIV16: count_tick = div_hit(div_q, DIV16_MASK);
      CKS_DIV4:  count_tick = div_hit(div_q, DIV4_MASK);
      CKS_SUB4:  count_tick = subclock_tick && sub_q == SUB_MASK;
      // msb clear: external event, edge chosen by the edge select
      default:   count_tick = event_edge_select ? (event_count_pin && !pin_q)
                                                : (!event_count_pin && pin_q);
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      sub_q <= '0;
      pin_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sub_q <= sub_d;
      pin_q <= pin_d;
    end
  end
endmodule
`default_nettype wire

// file: hdl/dual_mode_compare_timer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - flag bits ignore written ones, only clear
// - flag clears on zero write after read
// - 8-bit upper wrap sets upper overflow flag
// - 16-bit wrap sets upper overflow flag
// - lower wrap sets lower overflow flag
// - upper or 16-bit match sets upper flag
// - lower match sets lower match flag
// - bit 5 gates upper overflow request
// - bit 1 gates lower overflow request
// - bit 4 clears upper/16-bit counter on match
// - bit 0 clears lower counter on match in 8-bit mode only
// - status/control resets to zero
// - clock-stop bit 2 low halts timer
// - 8-bit mode bytes accessed directly
// - upper write to temp, lower commits both
// - upper read latches lower into temp
// - compare reads come straight from register
// - counter zero, compare ones at reset
// - upper select msb picks 8/16-bit mode
// - 16-bit match flags, requests, toggles upper
// - each 8-bit half matches on its own
// - overflow request needs both enables
// - lower select: event or divided clocks
// - level write drives toggle pin immediately
module dual_mode_compare_timer (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       bus_select,
  input  wire logic       bus_write,
  input  wire logic       bus_read,
  input  wire logic [2:0] bus_address,
  input  wire logic [7:0] bus_write_data,
  output logic      [7:0] bus_read_data,
  input  wire logic       event_count_pin,
  input  wire logic       event_edge_select,
  input  wire logic       subclock_tick,
  input  wire logic       upper_timer_irq_enable,
  input  wire logic       lower_timer_irq_enable,
  output logic            upper_toggle_pin,
  output logic            lower_toggle_pin,
  output logic            upper_irq,
  output logic            lower_irq
);
  import dual_mode_timer_pkg::*;

  logic [7:0] clock_level_q, clock_level_d;
  logic [7:0] status_q, status_d;
  logic [7:0] armed_q, armed_d;
  logic [7:0] clock_stop_q, clock_stop_d;
  logic [7:0] upper_counter_q, upper_counter_d;
  logic [7:0] lower_counter_q, lower_counter_d;
  logic [7:0] upper_compare_q, upper_compare_d;
  logic [7:0] lower_compare_q, lower_compare_d;
  logic [7:0] temp_q, temp_d;
  logic [7:0] read_data_q, read_data_d;
  logic       level_h_q, level_h_d;
  logic       level_l_q, level_l_d;
  logic       upper_irq_q, upper_irq_d;
  logic       lower_irq_q, lower_irq_d;

  logic        mode8, running, lower_sel_tick, upper_sel_tick, lower_tick, upper_tick;
  logic        wr_level, wr_status, wr_stop, wr_up_cnt, wr_lo_cnt, wr_up_cmp, wr_lo_cmp;
  logic        rd_status, rd_up_cnt;
  logic        lo_match, up_match, lo_match_evt, hi_match_evt, lo_clear, hi_clear;
  logic        ovf_h_evt, ovf_l_evt;
  logic [7:0]  set_v, clr_v;
  logic [15:0] count16;

  function automatic logic bus_hit(input logic strobe, input logic [2:0] addr,
                                   input logic [2:0] target);
    bus_hit = strobe && addr == target;
  endfunction

  assign mode8   = clock_level_q[BIT_CKS_H_HI];
  assign running = clock_stop_q[BIT_STANDBY_N];
  assign count16 = {upper_counter_q, lower_counter_q};

  clock_tick_select lower_select (
    .clock             (clock),
    .reset_n           (reset_n),
    .select            (clock_level_q[BIT_CKS_L_HI:BIT_CKS_L_LO]),
    .event_count_pin   (event_count_pin),
    .event_edge_select (event_edge_select),
    .subclock_tick     (subclock_tick),
    .count_tick        (lower_sel_tick)
  );

  clock_tick_select upper_select (
    .clock             (clock),
    .reset_n           (reset_n),
    .select            (clock_level_q[BIT_CKS_H_HI:BIT_CKS_H_LO]),
    .event_count_pin   (event_count_pin),
    .event_edge_select (event_edge_select),
    .subclock_tick     (subclock_tick),
    .count_tick        (upper_sel_tick)
  );

  always_comb begin
    wr_level  = bus_hit(bus_select && bus_write, bus_address, ADDR_CLOCK_LEVEL);
    wr_status = bus_hit(bus_select && bus_write, bus_address, ADDR_STATUS);
    wr_stop   = bus_hit(bus_select && bus_write, bus_address, ADDR_CLOCK_STOP);
    wr_up_cnt = bus_hit(bus_select && bus_write, bus_address, ADDR_UPPER_COUNT);
    wr_lo_cnt = bus_hit(bus_select && bus_write, bus_address, ADDR_LOWER_COUNT);
    wr_up_cmp = bus_hit(bus_select && bus_write, bus_address, ADDR_UPPER_COMPARE);
    wr_lo_cmp = bus_hit(bus_select && bus_write, bus_address, ADDR_LOWER_COMPARE);
    rd_status = bus_hit(bus_select && bus_read, bus_address, ADDR_STATUS);
    rd_up_cnt = bus_hit(bus_select && bus_read, bus_address, ADDR_UPPER_COUNT);

    // standby gates the count ticks; registers stay reachable
    lower_tick = running && lower_sel_tick;
    upper_tick = running && mode8 && upper_sel_tick;
    lo_match   = lower_counter_q == lower_compare_q;
    up_match   = upper_counter_q == upper_compare_q;

    // match fires as the counter leaves the matching value; a compare
    // write in the same cycle cancels it
    lo_match_evt = lower_tick && lo_match && !wr_lo_cmp;
    if (mode8) begin
      hi_match_evt = upper_tick && up_match && !wr_up_cmp;
    end else begin
      hi_match_evt = lower_tick && lo_match && up_match && !wr_lo_cmp;
    end
    lo_clear = lo_match_evt && mode8 && status_q[BIT_CCLR_L];
    hi_clear = hi_match_evt && status_q[BIT_CCLR_H];

    upper_counter_d = upper_counter_q;
    lower_counter_d = lower_counter_q;
    upper_compare_d = upper_compare_q;
    lower_compare_d = lower_compare_q;
    temp_d          = temp_q;
    ovf_h_evt       = 1'b0;
    ovf_l_evt       = 1'b0;
    if (mode8) begin
      if (lower_tick) begin
        if (lo_clear) begin
          lower_counter_d = COUNT_RESET;
        end else begin
          lower_counter_d = lower_counter_q + 8'h01;
          ovf_l_evt       = lower_counter_q == COUNT_MAX;
        end
      end
      if (upper_tick) begin
        if (hi_clear) begin
          upper_counter_d = COUNT_RESET;
        end else begin
          upper_counter_d = upper_counter_q + 8'h01;
          ovf_h_evt       = upper_counter_q == COUNT_MAX;
        end
      end
    end else if (lower_tick) begin
      if (hi_clear) begin
        {upper_counter_d, lower_counter_d} = {COUNT_RESET, COUNT_RESET};
      end else begin
        {upper_counter_d, lower_counter_d} = count16 + 16'h0001;
        ovf_h_evt = count16 == {COUNT_MAX, COUNT_MAX};
        ovf_l_evt = lower_counter_q == COUNT_MAX;
      end
    end

    // cpu writes win over counting and suppress that half's overflow
    if (wr_up_cnt) begin
      if (mode8) begin
        upper_counter_d = bus_write_data;
        ovf_h_evt       = 1'b0;
      end else begin
        temp_d = bus_write_data;
      end
    end
    if (wr_lo_cnt) begin
      lower_counter_d = bus_write_data;
      ovf_l_evt       = 1'b0;
      if (!mode8) begin
        upper_counter_d = temp_q;
        ovf_h_evt       = 1'b0;
      end
    end
    if (wr_up_cmp) begin
      if (mode8) begin
        upper_compare_d = bus_write_data;
      end else begin
        temp_d = bus_write_data;
      end
    end
    if (wr_lo_cmp) begin
      lower_compare_d = bus_write_data;
      if (!mode8) begin
        upper_compare_d = temp_q;
      end
    end
    if (rd_up_cnt && !mode8) begin
      temp_d = lower_counter_q;
    end

    // flags: hardware set beats a software clear in the same cycle
    set_v             = '0;
    set_v[BIT_OVF_H]  = ovf_h_evt;
    set_v[BIT_CMF_H]  = hi_match_evt;
    set_v[BIT_OVF_L]  = ovf_l_evt;
    set_v[BIT_CMF_L]  = lo_match_evt;
    clr_v             = wr_status ? (~bus_write_data & armed_q & FLAG_MASK) : 8'h00;
    status_d = ((wr_status ? bus_write_data : status_q) & ~FLAG_MASK)
             | ((set_v | (status_q & ~clr_v)) & FLAG_MASK);
    armed_d  = (armed_q | (rd_status ? status_q : 8'h00)) & status_d & FLAG_MASK;

    clock_level_d = wr_level ? bus_write_data : clock_level_q;
    clock_stop_d  = wr_stop ? bus_write_data : clock_stop_q;

    // a level write overrides a toggle landing in the same cycle
    if (wr_level) begin
      level_h_d = bus_write_data[BIT_LEVEL_H];
      level_l_d = bus_write_data[BIT_LEVEL_L];
    end else begin
      level_h_d = level_h_q ^ hi_match_evt;
      level_l_d = level_l_q ^ (lo_match_evt && mode8);
    end

    upper_irq_d = upper_timer_irq_enable &&
                  ((status_q[BIT_OVF_H] && status_q[BIT_OVIE_H]) || status_q[BIT_CMF_H]);
    lower_irq_d = lower_timer_irq_enable &&
                  ((status_q[BIT_OVF_L] && status_q[BIT_OVIE_L]) || status_q[BIT_CMF_L]);

    read_data_d = read_data_q;
    if (bus_select && bus_read) begin
      case (bus_address)
        ADDR_CLOCK_LEVEL:   read_data_d = WRITE_ONLY_READ;
        ADDR_STATUS:        read_data_d = status_q;
        ADDR_UPPER_COUNT:   read_data_d = upper_counter_q;
        ADDR_LOWER_COUNT:   read_data_d = mode8 ? lower_counter_q : temp_q;
        ADDR_UPPER_COMPARE: read_data_d = upper_compare_q;
        ADDR_LOWER_COMPARE: read_data_d = lower_compare_q;
        ADDR_CLOCK_STOP:    read_data_d = clock_stop_q;
        default:            read_data_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_level_q   <= CLOCK_LEVEL_RESET;
      status_q        <= STATUS_RESET;
      armed_q         <= 8'h00;
      clock_stop_q    <= CLOCK_STOP_RESET;
      upper_counter_q <= COUNT_RESET;
      lower_counter_q <= COUNT_RESET;
      upper_compare_q <= COMPARE_RESET;
      lower_compare_q <= COMPARE_RESET;
      temp_q          <= 8'h00;
      read_data_q     <= 8'h00;
      level_h_q       <= 1'b0;
      level_l_q       <= 1'b0;
      upper_irq_q     <= 1'b0;
      lower_irq_q     <= 1'b0;
    end else begin
      clock_level_q   <= clock_level_d;
      status_q        <= status_d;
      armed_q         <= armed_d;
      clock_stop_q    <= clock_stop_d;
      upper_counter_q <= upper_counter_d;
      lower_counter_q <= lower_counter_d;
      upper_compare_q <= upper_compare_d;
      lower_compare_q <= lower_compare_d;
      temp_q          <= temp_d;
      read_data_q     <= read_data_d;
      level_h_q       <= level_h_d;
      level_l_q       <= level_l_d;
      upper_irq_q     <= upper_irq_d;
      lower_irq_q     <= lower_irq_d;
    end
  end

  assign bus_read_data    = read_data_q;
  assign upper_toggle_pin = level_h_q;
  assign lower_toggle_pin = level_l_q;
  assign upper_irq        = upper_irq_q;
  assign lower_irq        = lower_irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_upper_byte_write16;
    bus_select && bus_write && bus_address == ADDR_UPPER_COUNT && !mode8;
  endsequence
  sequence s_lower_byte_write16;
    bus_select && bus_write && bus_address == ADDR_LOWER_COUNT && !mode8;
  endsequence

  chk_flag_no_set: assert property (
    (wr_status && bus_write_data[BIT_OVF_H] && !status_q[BIT_OVF_H] && !ovf_h_evt)
    |=> !status_q[BIT_OVF_H])
    else $error("software set the upper overflow flag");
  chk_clear_unarmed: assert property (
    (wr_status && !bus_write_data[BIT_CMF_L] && status_q[BIT_CMF_L] && !armed_q[BIT_CMF_L])
    |=> status_q[BIT_CMF_L])
    else $error("match flag cleared without prior read");
  chk_lower_wrap: assert property (
    (lower_tick && lower_counter_q == COUNT_MAX && !lo_clear && !hi_clear && !wr_lo_cnt
     && !wr_up_cnt) |=> (lower_counter_q == COUNT_RESET && status_q[BIT_OVF_L]))
    else $error("lower wrap did not set lower overflow");
  chk_wrap_sixteen: assert property (
    (!mode8 && lower_tick && count16 == 16'hFFFF && !hi_clear && !wr_lo_cnt)
    |=> (count16 == 16'h0000 && status_q[BIT_OVF_H]))
    else $error("16-bit wrap did not set upper overflow");
  chk_upper_wrap8: assert property (
    (mode8 && upper_tick && upper_counter_q == COUNT_MAX && !hi_clear && !wr_up_cnt)
    |=> status_q[BIT_OVF_H])
    else $error("8-bit upper wrap did not set upper overflow");
  chk_lower_clear: assert property (
    (mode8 && lower_tick && lo_match && !wr_lo_cmp && !wr_lo_cnt && status_q[BIT_CCLR_L])
    |=> (lower_counter_q == COUNT_RESET && status_q[BIT_CMF_L]))
    else $error("lower match did not clear counter");
  chk_standby_hold: assert property (
    (!running && !wr_lo_cnt && !wr_up_cnt) |=> $stable(count16))
    else $error("counter moved in module standby");
  chk_level_write: assert property (
    wr_level |=> (upper_toggle_pin == $past(bus_write_data[BIT_LEVEL_H])
                  && lower_toggle_pin == $past(bus_write_data[BIT_LEVEL_L])))
    else $error("toggle pins did not take written level");
  chk_pair_write: assert property (
    s_upper_byte_write16 ##1 !bus_select ##1 s_lower_byte_write16
    |=> upper_counter_q == $past(bus_write_data, 3))
    else $error("paired write lost the upper byte");
  chk_read_latch: assert property (
    (rd_up_cnt && !mode8) |=> (temp_q == $past(lower_counter_q)
                               && bus_read_data == $past(upper_counter_q)))
    else $error("upper read did not latch lower byte");
  chk_irq_gate: assert property (
    upper_irq |-> $past(upper_timer_irq_enable))
    else $error("upper request without external enable");
endmodule
`default_nettype wire

// file: hdl/dual_mode_timer_pkg.sv
`default_nettype none
package dual_mode_timer_pkg;
  // byte addresses on the peripheral bus
  localparam logic [2:0] ADDR_CLOCK_LEVEL   = 3'h0;
  localparam logic [2:0] ADDR_STATUS        = 3'h1;
  localparam logic [2:0] ADDR_UPPER_COUNT   = 3'h2;
  localparam logic [2:0] ADDR_LOWER_COUNT   = 3'h3;
  localparam logic [2:0] ADDR_UPPER_COMPARE = 3'h4;
  localparam logic [2:0] ADDR_LOWER_COMPARE = 3'h5;
  localparam logic [2:0] ADDR_CLOCK_STOP    = 3'h6;

  // timer_status_control fields
  localparam int BIT_OVF_H  = 7;
  localparam int BIT_CMF_H  = 6;
  localparam int BIT_OVIE_H = 5;
  localparam int BIT_CCLR_H = 4;
  localparam int BIT_OVF_L  = 3;
  localparam int BIT_CMF_L  = 2;
  localparam int BIT_OVIE_L = 1;
  localparam int BIT_CCLR_L = 0;
  localparam logic [7:0] FLAG_MASK = 8'hCC;

  // clock_level_control fields
  localparam int BIT_LEVEL_H  = 7;
  localparam int BIT_CKS_H_HI = 6;
  localparam int BIT_CKS_H_LO = 4;
  localparam int BIT_LEVEL_L  = 3;
  localparam int BIT_CKS_L_HI = 2;
  localparam int BIT_CKS_L_LO = 0;

  // clock_stop_one field
  localparam int BIT_STANDBY_N = 2;

  // values after reset and fixed read values
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam logic [7:0] CLOCK_LEVEL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_STOP_RESET  = 8'hFF;
  localparam logic [7:0] COUNT_RESET       = 8'h00;
  localparam logic [7:0] COUNT_MAX         = 8'hFF;
  localparam logic [7:0] COMPARE_RESET     = 8'hFF;
  localparam logic [7:0] WRITE_ONLY_READ   = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // clock select codes and divider masks
  localparam logic [2:0] CKS_DIV32 = 3'h4;
  localparam logic [2:0] CKS_DIV16 = 3'h5;
  localparam logic [2:0] CKS_DIV4  = 3'h6;
  localparam logic [2:0] CKS_SUB4  = 3'h7;
  localparam int         PRESCALE_WIDTH = 5;
  localparam logic [4:0] DIV32_MASK = 5'h1F;
  localparam logic [4:0] DIV16_MASK = 5'h0F;
  localparam logic [4:0] DIV4_MASK  = 5'h03;
  localparam logic [1:0] SUB_MASK   = 2'h3;
endpackage
`default_nettype wire
